// ==== lrf_regs.svh ====
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the design files of the frame engine
`ifndef LRF_REGS_SVH
`define LRF_REGS_SVH
// ==========================================
// register offsets
`define LRF_OFS_CTRL 8'hC8
`define LRF_OFS_STAT 8'hC9
`define LRF_OFS_IRQEN 8'hCA
`define LRF_OFS_ERR 8'hCB
`define LRF_OFS_DLEN 8'hCF
`define LRF_OFS_IDENT 8'hD0
`define LRF_OFS_SEL 8'hD1
`define LRF_OFS_DATA 8'hD2
// ==========================================
// status field positions
`define LRF_S_RXOK 0
`define LRF_S_TXOK 1
`define LRF_S_IDOK 2
`define LRF_S_ERR 3
// ==========================================
// error field positions
`define LRF_E_BIT 0
`define LRF_E_CHK 1
`define LRF_E_PAR 2
`define LRF_E_SYNC 3
`define LRF_E_FRM 4
`define LRF_E_TMO 5
`define LRF_E_OVR 6
`define LRF_E_ABORT 7
// ==========================================
// command and configuration codes, reset values
`define LRF_CMD_ABORT 3'h0
`define LRF_CMD_TXHDR 3'h1
`define LRF_CMD_RXRSP 3'h2
`define LRF_CMD_TXRSP 3'h3
`define LRF_CONF_NOCRC 2'h1
`define LRF_CONF_NOTMO 2'h2
`define LRF_RST_REG 8'h00
`define LRF_RST_TX 1'b1
// ==========================================
// field values and timing
`define LRF_SYNC_BYTE 8'h55
`define LRF_CSUM_OK 8'hFF
`define LRF_MAX_LEN 4'h8
`define LRF_DIAG_ID_BASE 4'hF
`define LRF_CLK_HZ 25000000
`define LRF_BAUD_BPS 19200
`define LRF_BIT_CYC (`LRF_CLK_HZ / `LRF_BAUD_BPS)
`define LRF_BRK_TX_BITS 13
`define LRF_BRK_MIN_BITS 11
`define LRF_FRAME_MAX_BITS 173
`endif

// ==== lrf_pkg.sv ====
// types and helper functions of the frame engine
// assumes the header of constants is compiled alongside
package lrf_pkg;
  typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_BRK_RX = 3'b001, ST_BRK_TX = 3'b010,
    ST_WAIT = 3'b011, ST_CHAR = 3'b100} lrf_state_t;
  typedef enum logic [2:0] {PH_SYNC = 3'b000, PH_PID = 3'b001, PH_DATA = 3'b010,
    PH_CSUM = 3'b011, PH_UART = 3'b100} lrf_phase_t;
  // whole device state, registered in one place
  typedef struct packed {
    lrf_state_t st;
    lrf_phase_t ph;
    logic proto_sel;
    logic [1:0] conf;
    logic ena;
    logic [2:0] cmd;
    logic idok, txok, rxok;
    logic [7:0] err;
    logic [3:0] enir;
    logic [3:0] rxl, txl;
    logic [5:0] id;
    logic [2:0] idst;
    logic ainc;
    logic [2:0] idx;
    logic [7:0][7:0] buff;
    logic [7:0] urx;
    logic unread;
    logic [9:0] sh;
    logic [7:0] rsh;
    logic [3:0] bitn;
    logic [11:0] cyc;
    logic [15:0] brk;
    logic [7:0] csum;
    logic [3:0] cnt, len;
    logic txm;
    logic [11:0] tdiv;
    logic [7:0] tmo;
    logic tmo_run;
    logic tx;
    logic busy;
    logic [7:0] rdata;
    logic irq_ok, irq_err;
  } lrf_dev_t;
  // partner node state
  typedef struct packed {
    logic [13:0] tsh;
    logic [3:0] tn;
    logic [11:0] tcyc;
    logic tx;
    logic ready;
    logic [1:0] rst;
    logic [11:0] rcyc;
    logic [3:0] rbit;
    logic [7:0] rsh;
    logic rvalid;
    logic [7:0] rdata;
    logic rferr;
  } lrf_node_t;
  // identifier with its two parity bits on top
  function automatic logic [7:0] lrf_pid(input logic [5:0] id);
    return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction : lrf_pid
  // eight-bit add with end-around carry
  function automatic logic [7:0] lrf_cadd(input logic [7:0] s, input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, s} + {1'b0, b};
    return 8'(t[7:0] + {7'h00, t[8]});
  endfunction : lrf_cadd
endpackage : lrf_pkg

// ==== lrf_lin_if.sv ====
// single-wire bus joining the device end and a partner node
// assumes both ends drive 1 for recessive; the wire is their AND
`timescale 1ns/1ps
`default_nettype none
interface lrf_lin_if;
  logic dev_tx;
  logic node_tx;
  logic bus;
  // wired-and line level
  assign bus = dev_tx & node_tx;
  modport dev (output dev_tx, input bus);
  modport node (output node_tx, input bus);
endinterface : lrf_lin_if
`default_nettype wire

// ==== lrf_node.sv ====
// partner node: sends breaks and characters, receives characters
// assumes the user keeps i_tx_valid until o_tx_ready takes it
`timescale 1ns/1ps
`default_nettype none
`include "lrf_regs.svh"
module lrf_node #(
  parameter int BIT_CYCLES = `LRF_BIT_CYC
) (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // sync reset
  input wire logic i_tx_valid, // send request
  input wire logic i_tx_brk, // send break, not a byte
  input wire logic [7:0] i_tx_data, // byte to send
  output logic o_tx_ready, // request taken when high
  output logic o_rx_valid, // byte received pulse
  output logic [7:0] o_rx_data, // received byte
  output logic o_rx_ferr, // stop bit was dominant
  lrf_lin_if.node lin // bus
);
  localparam logic [11:0] LAST = 12'(BIT_CYCLES - 1);
  localparam logic [11:0] HALF = 12'(BIT_CYCLES / 2);
  lrf_pkg::lrf_node_t s, n;
  if (BIT_CYCLES < 8 || BIT_CYCLES > 4095)
  begin : g_chk
    $error("lrf_node: BIT_CYCLES out of range");
  end
  // ==========================================
  // transmit and receive engines
  always_comb
  begin
    n = s;
    n.rvalid = 1'b0;
    // transmitter: break is 13 dominant bits then one recessive
    if (s.tn == 4'h0)
    begin
      n.ready = 1'b1;
      if (i_tx_valid && s.ready)
      begin
        n.ready = 1'b0;
        n.tcyc = 12'h000;
        n.tsh = i_tx_brk ? 14'h2000 : {4'hF, 1'b1, i_tx_data, 1'b0};
        n.tn = i_tx_brk ? 4'(`LRF_BRK_TX_BITS + 1) : 4'hA;
        n.tx = 1'b0;
      end
    end
    else if (s.tcyc == LAST)
    begin
      n.tcyc = 12'h000;
      n.tsh = {1'b1, s.tsh[13:1]};
      n.tn = s.tn - 4'h1;
      n.tx = (s.tn == 4'h1) ? 1'b1 : s.tsh[1];
    end
    else
      n.tcyc = s.tcyc + 12'h001;
    // receiver: idle, in a character, or waiting for recessive
    case (s.rst)
      2'h0:
        if (!lin.bus)
        begin
          n.rst = 2'h1;
          n.rcyc = 12'h000;
          n.rbit = 4'h0;
        end
      2'h1:
      begin
        n.rcyc = (s.rcyc == LAST) ? 12'h000 : s.rcyc + 12'h001;
        if (s.rcyc == LAST)
          n.rbit = s.rbit + 4'h1;
        if (s.rcyc == HALF)
        begin
          if (s.rbit != 4'h0 && s.rbit != 4'h9)
            n.rsh = {lin.bus, s.rsh[7:1]};
          if (s.rbit == 4'h9)
          begin
            n.rvalid = 1'b1;
            n.rdata = s.rsh;
            n.rferr = !lin.bus;
            n.rst = lin.bus ? 2'h0 : 2'h2;
          end
        end
      end
      default:
        if (lin.bus)
          n.rst = 2'h0;
    endcase
  end
  // state register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      s <= '0;
      s.tx <= `LRF_RST_TX;
    end
    else
      s <= n;
  end
  assign lin.node_tx = s.tx;
  assign o_tx_ready = s.ready;
  assign o_rx_valid = s.rvalid;
  assign o_rx_data = s.rdata;
  assign o_rx_ferr = s.rferr;
endmodule : lrf_node
`default_nettype wire

// ==== lrf_dev.sv ====
// device end: lin/uart response engine with its register port
// assumes a byte-wide register port and the bus through lrf_lin_if
`timescale 1ns/1ps
`default_nettype none
`include "lrf_regs.svh"
module lrf_dev #(
  parameter int BIT_CYCLES = `LRF_BIT_CYC,
  parameter int FRAME_MAX_BITS = `LRF_FRAME_MAX_BITS
) (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // sync reset
  input wire logic i_wr, // register write strobe
  input wire logic i_rd, // register read strobe
  input wire logic [7:0] i_addr, // register offset
  input wire logic [7:0] i_wdata, // write data
  output logic [7:0] o_rdata, // read data, one cycle late
  output logic o_irq_ok, // completion interrupt
  output logic o_irq_err, // error interrupt
  output logic o_busy, // busy signal
  lrf_lin_if.dev lin // bus
);
  localparam logic [11:0] LAST = 12'(BIT_CYCLES - 1);
  localparam logic [11:0] HALF = 12'(BIT_CYCLES / 2);
  localparam logic [15:0] BRK_MIN = 16'(`LRF_BRK_MIN_BITS * BIT_CYCLES);
  localparam logic [15:0] BRK_LOW = 16'(`LRF_BRK_TX_BITS * BIT_CYCLES);
  localparam logic [15:0] BRK_END = 16'((`LRF_BRK_TX_BITS + 1) * BIT_CYCLES - 1);
  localparam logic [7:0] TMO_MAX = 8'(FRAME_MAX_BITS);
  lrf_pkg::lrf_dev_t s, n;
  lrf_pkg::lrf_phase_t ldph;
  logic ld, last, ew, nocrc;
  logic [7:0] ldb, cb, errs, init;
  logic [3:0] cnt1, clen;
  logic [2:0] cw;
  if (BIT_CYCLES < 8 || BIT_CYCLES > 4095 || FRAME_MAX_BITS < 1 || FRAME_MAX_BITS > 254)
  begin : g_chk
    $error("lrf_dev: parameter out of range");
  end
  // ==========================================
  // next-state logic
  always_comb
  begin
    n = s;
    errs = 8'h00;
    ld = 1'b0;
    ldb = 8'h00;
    ldph = lrf_pkg::PH_DATA;
    cb = s.csum;
    last = 1'b0;
    cnt1 = s.cnt + 4'h1;
    cw = i_wdata[2:0];
    ew = i_wdata[3];
    nocrc = (s.conf == `LRF_CONF_NOCRC);
    init = i_wdata[6] ? 8'h00 : lrf_pkg::lrf_pid(s.id);
    clen = (s.rxl > `LRF_MAX_LEN) ? `LRF_MAX_LEN : s.rxl;
    // flag clears first so a set in the same cycle wins
    if (i_wr && i_addr == `LRF_OFS_STAT)
    begin
      if (i_wdata[`LRF_S_RXOK])
        n.rxok = 1'b0;
      if (i_wdata[`LRF_S_TXOK])
        n.txok = 1'b0;
      if (i_wdata[`LRF_S_IDOK])
        n.idok = 1'b0;
      if (i_wdata[`LRF_S_ERR])
        n.err = 8'h00;
    end
    if (s.cmd[2] && i_addr == `LRF_OFS_DATA)
    begin
      if (i_wr)
      begin
        n.rxok = 1'b0;
        n.txok = 1'b0;
      end
      if (i_rd)
      begin
        n.err = 8'h00;
        n.unread = 1'b0;
      end
    end
    // frame timer in bit times
    if (s.tmo_run)
    begin
      n.tdiv = (s.tdiv == LAST) ? 12'h000 : s.tdiv + 12'h001;
      if (s.tdiv == LAST && s.tmo != 8'hFF)
        n.tmo = s.tmo + 8'h01;
      if (s.tmo >= TMO_MAX && s.conf != `LRF_CONF_NOCRC && s.conf != `LRF_CONF_NOTMO)
        errs[`LRF_E_TMO] = 1'b1;
    end
    // serial engine
    case (s.st)
      lrf_pkg::ST_IDLE:
        if (s.ena && s.cmd[2] && s.cmd[1] && !lin.bus)
        begin
          n.st = lrf_pkg::ST_CHAR;
          n.ph = lrf_pkg::PH_UART;
          n.txm = 1'b0;
          n.cyc = 12'h000;
          n.bitn = 4'h0;
        end
      lrf_pkg::ST_BRK_RX:
        if (!lin.bus)
          n.brk = (s.brk == 16'hFFFF) ? s.brk : s.brk + 16'h0001;
        else
        begin
          n.brk = 16'h0000;
          if (s.brk >= BRK_MIN)
          begin
            n.st = lrf_pkg::ST_WAIT;
            n.ph = lrf_pkg::PH_SYNC;
            n.tmo_run = 1'b1;
            n.tmo = 8'h00;
            n.tdiv = 12'h000;
          end
        end
      lrf_pkg::ST_BRK_TX:
      begin
        n.brk = s.brk + 16'h0001;
        n.tx = (s.brk >= BRK_LOW - 16'h0001);
        if (s.brk == BRK_END)
        begin
          ld = 1'b1;
          ldb = `LRF_SYNC_BYTE;
          ldph = lrf_pkg::PH_SYNC;
          n.tmo_run = 1'b1;
          n.tmo = 8'h00;
          n.tdiv = 12'h000;
        end
      end
      lrf_pkg::ST_WAIT:
        if (!lin.bus)
        begin
          n.st = lrf_pkg::ST_CHAR;
          n.txm = 1'b0;
          n.cyc = 12'h000;
          n.bitn = 4'h0;
        end
      default:
      begin
        n.cyc = (s.cyc == LAST) ? 12'h000 : s.cyc + 12'h001;
        // low run kept so a break inside a byte still counts in full
        n.brk = lin.bus ? 16'h0000 : s.brk + 16'h0001;
        if (s.cyc == LAST)
        begin
          n.bitn = s.bitn + 4'h1;
          n.sh = {1'b1, s.sh[9:1]};
          n.tx = s.sh[1];
        end
        if (s.cyc == HALF)
        begin
          if (s.txm && lin.bus != s.tx)
            errs[`LRF_E_BIT] = 1'b1;
          if (s.bitn != 4'h0 && s.bitn != 4'h9)
            n.rsh = {lin.bus, s.rsh[7:1]};
          if (s.bitn == 4'h9 && !lin.bus)
            errs[`LRF_E_FRM] = 1'b1;
        end
        last = (s.bitn == 4'h9) && (s.txm ? s.cyc == LAST : s.cyc == HALF);
        if (last && errs == 8'h00)
        begin
          n.st = lrf_pkg::ST_IDLE;
          case (s.ph)
            lrf_pkg::PH_SYNC:
              if (s.txm)
              begin
                ld = 1'b1;
                ldb = lrf_pkg::lrf_pid(s.id);
                ldph = lrf_pkg::PH_PID;
              end
              else if (s.rsh != `LRF_SYNC_BYTE)
                errs[`LRF_E_SYNC] = 1'b1;
              else
              begin
                n.st = lrf_pkg::ST_WAIT;
                n.ph = lrf_pkg::PH_PID;
              end
            lrf_pkg::PH_PID:
            begin
              if (!s.txm)
                n.id = s.rsh[5:0];
              if (!s.txm && lrf_pkg::lrf_pid(s.rsh[5:0]) != s.rsh)
                errs[`LRF_E_PAR] = 1'b1;
              else
              begin
                n.idok = 1'b1;
                n.idst = (n.id[5:2] == `LRF_DIAG_ID_BASE) ? {1'b1, n.id[1:0]} : 3'b000;
                if (s.proto_sel)
                begin
                  n.rxl = n.id[5] ? (n.id[4] ? 4'h8 : 4'h4) : 4'h2;
                  n.txl = n.rxl;
                end
              end
            end
            lrf_pkg::PH_DATA:
            begin
              n.cnt = cnt1;
              if (s.txm)
                n.rxl = cnt1;
              else
              begin
                n.txl = cnt1;
                n.buff[s.cnt[2:0]] = s.rsh;
                n.csum = lrf_pkg::lrf_cadd(s.csum, s.rsh);
              end
              if (cnt1 == s.len && nocrc)
              begin
                n.rxok = !s.txm;
                n.txok = s.txm;
                n.tmo_run = 1'b0;
              end
              else if (s.txm)
              begin
                ld = 1'b1;
                ldb = (cnt1 == s.len) ? ~s.csum : s.buff[cnt1[2:0]];
                ldph = (cnt1 == s.len) ? lrf_pkg::PH_CSUM : lrf_pkg::PH_DATA;
              end
              else
              begin
                n.st = lrf_pkg::ST_WAIT;
                n.ph = (cnt1 == s.len) ? lrf_pkg::PH_CSUM : lrf_pkg::PH_DATA;
              end
            end
            lrf_pkg::PH_CSUM:
            begin
              n.tmo_run = 1'b0;
              if (!s.txm && lrf_pkg::lrf_cadd(s.csum, s.rsh) != `LRF_CSUM_OK)
                errs[`LRF_E_CHK] = 1'b1;
              else
              begin
                n.rxok = !s.txm;
                n.txok = s.txm;
              end
            end
            default:
            begin
              if (!s.txm)
              begin
                if (s.unread)
                  errs[`LRF_E_OVR] = 1'b1;
                n.urx = s.rsh;
                n.unread = 1'b1;
              end
              n.rxok = !s.txm ? 1'b1 : n.rxok;
              n.txok = s.txm ? 1'b1 : n.txok;
            end
          endcase
        end
      end
    endcase
    // ==========================================
    // register writes and commands
    if (i_wr)
    begin
      if (i_addr == `LRF_OFS_CTRL)
      begin
        n.cmd = cw;
        n.ena = ew;
        if (s.busy && ew && cw != `LRF_CMD_ABORT)
        begin
          n.cmd = s.cmd;
          n.err[`LRF_E_OVR] = 1'b1;
        end
        else if (s.busy && ew)
        begin
          n.err[`LRF_E_ABORT] = 1'b1;
          n.st = lrf_pkg::ST_BRK_RX;
          n.brk = 16'h0000;
          n.tx = 1'b1;
          n.tmo_run = 1'b0;
        end
        else if (!ew || cw[2])
        begin
          n.proto_sel = s.busy ? s.proto_sel : i_wdata[6];
          n.conf = s.busy ? s.conf : i_wdata[5:4];
          n.st = lrf_pkg::ST_IDLE;
          n.tx = 1'b1;
          n.tmo_run = 1'b0;
        end
        else
        begin
          n.proto_sel = i_wdata[6];
          n.conf = i_wdata[5:4];
          n.cnt = 4'h0;
          n.csum = init;
          n.brk = 16'h0000;
          case (cw)
            `LRF_CMD_ABORT:
              n.st = lrf_pkg::ST_BRK_RX;
            `LRF_CMD_TXHDR:
            begin
              n.st = lrf_pkg::ST_BRK_TX;
              n.tx = 1'b0; // break low from this edge, 13 whole bits
            end
            `LRF_CMD_RXRSP:
            begin
              n.len = i_wdata[6] ? s.rxl : clen;
              n.rxl = n.len;
              n.txl = 4'h0;
              n.st = lrf_pkg::ST_WAIT;
              n.ph = (n.len == 4'h0) ? lrf_pkg::PH_CSUM : lrf_pkg::PH_DATA;
            end
            default:
            begin
              n.len = (!i_wdata[6] && s.txl > `LRF_MAX_LEN) ? `LRF_MAX_LEN : s.txl;
              n.txl = n.len;
              n.rxl = 4'h0;
              ld = 1'b1;
              cb = init;
              ldb = (n.len == 4'h0) ? ~init : s.buff[0];
              ldph = (n.len == 4'h0) ? lrf_pkg::PH_CSUM : lrf_pkg::PH_DATA;
            end
          endcase
        end
      end
      else if (i_addr == `LRF_OFS_IRQEN)
        n.enir = i_wdata[3:0];
      else if (i_addr == `LRF_OFS_DLEN && !s.busy && !s.cmd[2])
        {n.txl, n.rxl} = i_wdata;
      else if (i_addr == `LRF_OFS_IDENT && !s.busy)
        n.id = i_wdata[5:0];
      else if (i_addr == `LRF_OFS_SEL)
        {n.ainc, n.idx} = i_wdata[3:0];
      else if (i_addr == `LRF_OFS_DATA && !s.busy)
      begin
        if (!s.cmd[2])
          n.buff[s.idx] = i_wdata;
        else if (s.ena && s.cmd[0])
        begin
          ld = 1'b1;
          ldb = i_wdata;
          ldph = lrf_pkg::PH_UART;
        end
      end
    end
    // data index steps after each data access in frame mode while SEL bit 3 is clear
    if ((i_wr || i_rd) && i_addr == `LRF_OFS_DATA && !s.cmd[2] && !s.ainc)
      n.idx = s.idx + 3'h1;
    // start sending one character
    if (ld)
    begin
      n.st = lrf_pkg::ST_CHAR;
      n.ph = ldph;
      n.txm = 1'b1;
      n.sh = {1'b1, ldb, 1'b0};
      n.tx = 1'b0;
      n.cyc = 12'h000;
      n.bitn = 4'h0;
      n.brk = 16'h0000;
      if (ldph == lrf_pkg::PH_DATA)
        n.csum = lrf_pkg::lrf_cadd(cb, ldb);
    end
    // errors stop the transfer and, outside uart mode, withdraw the command
    if (errs != 8'h00)
    begin
      n.err = n.err | errs;
      n.tx = 1'b1;
      n.tmo_run = 1'b0;
      n.brk = (s.st == lrf_pkg::ST_CHAR && !lin.bus) ? n.brk : 16'h0000;
      n.st = (s.ena && !s.cmd[2]) ? lrf_pkg::ST_BRK_RX : lrf_pkg::ST_IDLE;
      if (!s.cmd[2])
        n.cmd = `LRF_CMD_ABORT;
    end
    if (n.cmd[2])
    begin
      n.rxl = 4'h0;
      n.txl = 4'h0;
    end
    n.busy = n.st != lrf_pkg::ST_IDLE && n.st != lrf_pkg::ST_BRK_RX && !(n.ph == lrf_pkg::PH_UART && !n.txm);
    n.irq_ok = (n.rxok & n.enir[0]) | (n.txok & n.enir[1]) | (n.idok & n.enir[2]);
    n.irq_err = (|n.err) & n.enir[3];
    // registered read data
    if (i_rd)
    begin
      if (i_addr == `LRF_OFS_CTRL)
        n.rdata = {1'b0, s.proto_sel, s.conf, s.ena, s.cmd};
      else if (i_addr == `LRF_OFS_STAT)
        n.rdata = {s.idst, s.busy, |s.err, s.idok, s.txok, s.rxok};
      else if (i_addr == `LRF_OFS_IRQEN)
        n.rdata = {4'h0, s.enir};
      else if (i_addr == `LRF_OFS_ERR)
        n.rdata = s.err;
      else if (i_addr == `LRF_OFS_DLEN)
        n.rdata = {s.txl, s.rxl};
      else if (i_addr == `LRF_OFS_IDENT)
        n.rdata = lrf_pkg::lrf_pid(s.id);
      else if (i_addr == `LRF_OFS_SEL)
        n.rdata = {4'h0, s.ainc, s.idx};
      else if (i_addr == `LRF_OFS_DATA)
        n.rdata = s.cmd[2] ? s.urx : s.buff[s.idx];
      else
        n.rdata = `LRF_RST_REG;
    end
  end
  // state register, lengths zero from reset
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      s <= '0;
      s.tx <= `LRF_RST_TX;
    end
    else
      s <= n;
  end
  assign lin.dev_tx = s.tx;
  assign o_rdata = s.rdata;
  assign o_irq_ok = s.irq_ok;
  assign o_irq_err = s.irq_err;
  assign o_busy = s.busy;
endmodule : lrf_dev
`default_nettype wire

// ==== lrf_lin_asserts.sv ====
// checker of the single wire between the device end and the node end
// assumes 8 clocks per bit on both ends and a 13-bit break
`timescale 1ns/1ps
`default_nettype none
module lrf_lin_asserts (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // sync reset
  input wire logic dev_tx, // device drive
  input wire logic node_tx, // node drive
  input wire logic bus // wire level
);
  // ========
  // length of the current low run of the device drive
  logic [7:0] low_r;
  logic [7:0] low_nxt;
  always_comb low_nxt = dev_tx ? 8'h00 : low_r + 8'h01;
  // registers the low run length
  always_ff @(posedge i_clk) low_r <= i_rst_n ? low_nxt : 8'h00;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ========
  // wire relations
  a_wire_and: assert property (bus == (dev_tx & node_tx)) else $error("wire is not the and of drives");
  a_idle_release: assert property ($rose(i_rst_n) |-> dev_tx && node_tx) else $error("drive low at release");
  a_dev_low_bit: assert property ($fell(dev_tx) |-> !dev_tx [*8]) else $error("device low bit too short");
  a_dev_high_bit: assert property ($rose(dev_tx) |-> dev_tx [*8]) else $error("device high bit too short");
  a_node_low_bit: assert property ($fell(node_tx) |-> !node_tx [*8]) else $error("node low bit too short");
  a_node_high_bit: assert property ($rose(node_tx) |-> node_tx [*8]) else $error("node high bit too short");
  a_break_max: assert property (low_r <= 8'h68) else $error("device low longer than a break");
  a_low_ends: assert property ($fell(dev_tx) |-> ##[1:105] dev_tx) else $error("device low run not ended");
  // main scenarios
  c_dev_sends: cover property ($fell(dev_tx));
  c_node_sends: cover property ($fell(node_tx));
  c_break_done: cover property (low_r == 8'h68);
endmodule : lrf_lin_asserts
`default_nettype wire

// ==== lin_response_frame_engine_test.sv ====
// bench joining the device end and the node end over one wire
// assumes 8-clock bits on both ends and a 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
module lin_response_frame_engine_test;
  logic clk, rst_n, wr, rd, nv, nb, irq_ok, irq_err, busy, nrdy, rxv, rxf;
  logic [7:0] addr, wdata, nd, rdata, rxd;
  int fail_count = 0;
  int tests_run = 0;
  // reset value rows: offset, expected read
  logic [15:0] rows [9] = '{16'hC800, 16'hC900, 16'hCA00, 16'hCB00, 16'hCF00, 16'hD080, 16'hD100, 16'hD200,
    16'h7F00};
  // ========
  // both ends on one wire, checker beside it
  lrf_lin_if i_lrf_lin_if ();
  lrf_dev #(.BIT_CYCLES(8), .FRAME_MAX_BITS(60)) i_lrf_dev (.i_clk(clk), .i_rst_n(rst_n), .i_wr(wr),
    .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_irq_ok(irq_ok), .o_irq_err(irq_err),
    .o_busy(busy), .lin(i_lrf_lin_if));
  lrf_node #(.BIT_CYCLES(8)) i_lrf_node (.i_clk(clk), .i_rst_n(rst_n), .i_tx_valid(nv), .i_tx_brk(nb),
    .i_tx_data(nd), .o_tx_ready(nrdy), .o_rx_valid(rxv), .o_rx_data(rxd), .o_rx_ferr(rxf), .lin(i_lrf_lin_if));
  lrf_lin_asserts i_lrf_lin_asserts (.i_clk(clk), .i_rst_n(rst_n), .dev_tx(i_lrf_lin_if.dev_tx),
    .node_tx(i_lrf_lin_if.node_tx), .bus(i_lrf_lin_if.bus));
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ========
  // reporting
  task automatic bad(input string m);
    fail_count++;
    $display("mismatch %0t %s", $time, m);
  endtask : bad
  task automatic stop_test;
    if (fail_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  // bounded wait: 0 device idle, 1 node ready, 2 node character
  task automatic wt(input int k);
    int n;
    n = 0;
    while (!(k == 0 ? busy === 1'b0 : k == 1 ? nrdy === 1'b1 : rxv === 1'b1 && rxf === 1'b0) && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000)
    begin
      bad("wait ran out");
      stop_test();
    end
  endtask : wt
  // register write, one strobe cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wr_reg
  // register read, data one cycle later
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    tests_run++;
    if (rdata !== e)
      bad($sformatf("read %h got %h", a, rdata));
    @(negedge clk);
  endtask : rd_chk
  // node sends one byte, held until taken
  task automatic nsend(input logic [7:0] d);
    nd = d;
    nv = 1'b1;
    wt(1);
    @(negedge clk);
    nv = 1'b0;
    @(negedge clk);
  endtask : nsend
  // node receives one good character, breaks skipped
  task automatic nrx(input logic [7:0] e);
    wt(2);
    tests_run++;
    if (rxd !== e)
      bad($sformatf("node got %h", rxd));
    @(negedge clk);
  endtask : nrx
  // master header with identifier 0x3C
  task automatic hdr;
    wr_reg(8'hC8, 8'h09);
    nrx(8'h55);
    nrx(8'h3C);
    wt(0);
  endtask : hdr
  // ========
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    {wr, rd, nv, nb} = '0;
    {addr, wdata, nd} = '0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i])
      rd_chk(rows[i][15:8], rows[i][7:0]);
    // header then two-byte tx response, classic sum
    wr_reg(8'hD0, 8'h3C);
    wr_reg(8'hCF, 8'h20);
    wr_reg(8'hD1, 8'h00);
    wr_reg(8'hD2, 8'h11);
    wr_reg(8'hD2, 8'h22);
    hdr();
    rd_chk(8'hC9, 8'h84);
    wr_reg(8'hC8, 8'h4B);
    nrx(8'h11);
    nrx(8'h22);
    nrx(8'hCC);
    wt(0);
    rd_chk(8'hC9, 8'h86);
    rd_chk(8'hCF, 8'h22);
    // one-byte rx response, enhanced sum, completion interrupt
    wr_reg(8'hC9, 8'h07);
    wr_reg(8'hCA, 8'h09);
    wr_reg(8'hCF, 8'h01);
    hdr();
    wr_reg(8'hC9, 8'h07);
    wr_reg(8'hC8, 8'h0A);
    nsend(8'hA5);
    nsend(8'h1E);
    wt(0);
    rd_chk(8'hC9, 8'h81);
    rd_chk(8'hCF, 8'h11);
    tests_run++;
    if (irq_ok !== 1'b1) bad("no completion interrupt");
    wr_reg(8'hD1, 8'h00);
    rd_chk(8'hD2, 8'hA5);
    // wrong checksum: flag, withdrawal, count, clear
    wr_reg(8'hC9, 8'h07);
    hdr();
    wr_reg(8'hC8, 8'h0A);
    nsend(8'hA5);
    nsend(8'h1F);
    wt(0);
    rd_chk(8'hCB, 8'h02);
    rd_chk(8'hC9, 8'h8C);
    rd_chk(8'hC8, 8'h08);
    rd_chk(8'hCF, 8'h11);
    tests_run++;
    if (irq_err !== 1'b1) bad("no error interrupt");
    wr_reg(8'hC9, 8'h08);
    rd_chk(8'hCB, 8'h00);
    // command then abort while busy
    wr_reg(8'hC8, 8'h0A);
    wr_reg(8'hC8, 8'h09);
    wr_reg(8'hC8, 8'h08);
    rd_chk(8'hCB, 8'hC0);
    tests_run++;
    if (busy !== 1'b0) bad("still busy after abort");
    hdr();
    rd_chk(8'hC9, 8'h8C);
    // index roll-over from 7 to 0
    wr_reg(8'hD1, 8'h07);
    wr_reg(8'hD2, 8'h5A);
    wr_reg(8'hD2, 8'hC3);
    wr_reg(8'hD1, 8'h07);
    rd_chk(8'hD2, 8'h5A);
    rd_chk(8'hD2, 8'hC3);
    // uart: lengths held at zero, one character each way, overrun
    wr_reg(8'hC9, 8'h0F);
    wr_reg(8'hC8, 8'h0F);
    wr_reg(8'hCF, 8'h33);
    rd_chk(8'hCF, 8'h00);
    wr_reg(8'hD2, 8'h96);
    nrx(8'h96);
    wt(0);
    nsend(8'h69);
    wt(1);
    rd_chk(8'hC9, 8'h83);
    rd_chk(8'hD2, 8'h69);
    nsend(8'h5A);
    nsend(8'hA5);
    wt(1);
    rd_chk(8'hCB, 8'h40);
    // slave: header from the node, then a break where a data byte belongs
    wr_reg(8'hC9, 8'h0F);
    wr_reg(8'hC8, 8'h08);
    wr_reg(8'hCF, 8'h02);
    for (int k = 0; k < 2; k++)
    begin
      nb = 1'b1;
      nsend(8'h00);
      nb = 1'b0;
      nsend(8'h55);
      nsend(8'h3C);
      wt(1);
      if (k == 0)
      begin
        rd_chk(8'hC9, 8'h84);
        wr_reg(8'hC9, 8'h07);
        wr_reg(8'hC8, 8'h0A);
        nsend(8'hA5);
      end
    end
    rd_chk(8'hCB, 8'h10);
    rd_chk(8'hC9, 8'h8C);
    rd_chk(8'hCF, 8'h12);
    stop_test();
  end
endmodule : lin_response_frame_engine_test
`default_nettype wire
